// ===== rtl/sdpd_pkg.sv
// package: register map, field positions and carriers for port d
package sdpd_pkg;
	localparam int SDPD_W_MAX = 8;
	localparam logic [3:0] SDPD_OFS_PIN   = 4'h0;
	localparam logic [3:0] SDPD_OFS_DIR   = 4'h1;
	localparam logic [3:0] SDPD_OFS_LATCH = 4'h2;
	localparam logic [3:0] SDPD_OFS_MEMCTL = 4'h3;
	localparam logic [3:0] SDPD_OFS_LATCH_A_REGISTER  = 4'h4;
	localparam logic [3:0] SDPD_OFS_PPCTL = 4'h5;
	localparam logic [3:0] SDPD_OFS_PPIN  = 4'h6;
	localparam int SDPD_BIT_EXT_BUS_DIS = 7;
	localparam int SDPD_BIT_PULLUP_EN   = 7;
	localparam int SDPD_BIT_PAR_SLAVE   = 4;
	localparam logic [7:0] SDPD_RST_DIR    = 8'hff;
	localparam logic [7:0] SDPD_RST_LATCH  = 8'h00;
	localparam logic [7:0] SDPD_RST_MEMCTL = 8'h00;
	localparam logic [7:0] SDPD_RST_LATCH_A_REGISTER   = 8'h80;
	localparam logic [7:0] SDPD_RST_PPCTL  = 8'h00;

	// one pin's competing sources: enable and value per function
	typedef struct packed {
		logic bus_oe;
		logic bus_out;
		logic pwm_oe;
		logic pwm_tri;
		logic pwm_out;
		logic par_oe;
		logic par_out;
		logic dir;
		logic lat;
	} sdpd_pin_src_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sdpd_bus_req_s;
endpackage : sdpd_pkg

// ===== rtl/sdpd_pin_mux.sv
// module: per-pin output priority multiplexer and pull-up gate
`timescale 1ns/1ps
`default_nettype none
module sdpd_pin_mux
	import sdpd_pkg::*;
(
	// sources
	input  wire sdpd_pin_src_s src,
	input  wire logic          pullup_en,
	// pin drive
	output logic               pin_out,
	output logic               pin_oe,
	output logic               pin_pull
);
	always_comb
	begin
		if (src.bus_oe)
		begin
			pin_out = src.bus_out;
			pin_oe  = 1'b1;
		end
		else if (src.pwm_oe)
		begin
			pin_out = src.pwm_out;
			pin_oe  = ~src.pwm_tri;
		end
		else if (src.par_oe)
		begin
			pin_out = src.par_out;
			pin_oe  = 1'b1;
		end
		else
		begin
			pin_out = src.lat;
			pin_oe  = ~src.dir;
		end
	end
	// pull-up only while nothing drives; keeps no contention with driver
	assign pin_pull = pullup_en & ~pin_oe;
endmodule : sdpd_pin_mux
`default_nettype wire

// ===== rtl/sdpd_port.sv
// module: shared digital port d with register file and pin priority
//
// What this block does
// - three pins on small packages, eight on the largest
// - direction bit one makes the pin an input, driver off
// - direction bit zero drives the latch bit onto the pin
// - latch register reads back latched values, not pin levels
// - every reset makes all pins digital inputs
// - on the largest package, port usable only while external bus disable bit is set
// - enabled external bus overrides direction bits
// - shared pull-up enable bit clears all pull-ups together
// - pull-up off on any pin while the port drives it
// - reset turns pull-ups on
// - parallel-slave bit makes an 8-bit microprocessor port
// - parallel port beats port data but loses to external bus
// - parallel read drives latch, write captures pins, ignoring direction
// - active external bus drives or captures regardless of direction
// - pwm channel b on bit 0 overrides port and parallel data
// - compare unit on bit 1 overrides port; input feeds capture
// - compare unit on bit 2 overrides port; input feeds capture
// - pwm channels a and d on bits 1, 2 override, may tristate
// - external bus beats every other function
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sdpd_port
	import sdpd_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	// clock and reset
	input  wire logic             SYS_CLK,
	input  wire logic             RST_N,
	input  wire logic             CLK_EN,
	// register port
	input  wire logic [3:0]       REG_ADDR,
	input  wire logic [7:0]       REG_WDATA,
	input  wire logic             REG_WR,
	input  wire logic             REG_RD,
	output logic      [7:0]       REG_RDATA,
	// external bus, low address/data byte
	input  wire logic             EXT_BUS_ACTIVE,
	input  wire logic             EXT_BUS_OE,
	input  wire logic [WIDTH-1:0] EXT_BUS_DOUT,
	output logic      [WIDTH-1:0] EXT_BUS_DIN,
	// parallel slave host strobes, already synchronous
	input  wire logic             PAR_HOST_RD,
	input  wire logic             PAR_HOST_WR,
	// pwm and compare outputs for bits 0 to 2
	input  wire logic [2:0]       PWM_SEL,
	input  wire logic [2:0]       PWM_OUT,
	input  wire logic [2:0]       PWM_SHUTDOWN_TRI,
	output logic      [2:0]       CAPTURE_IN,
	// pins
	input  wire logic [WIDTH-1:0] PIN_I,
	output logic      [WIDTH-1:0] PIN_O,
	output logic      [WIDTH-1:0] PIN_OE,
	output logic      [WIDTH-1:0] PIN_PULLUP
);
	initial
	begin
		if (WIDTH != 3 && WIDTH != SDPD_W_MAX)
			$error("sdpd_port: WIDTH must be 3 or 8");
	end

	localparam bit BIG = (WIDTH == SDPD_W_MAX);
	localparam int PIN_W = WIDTH;

	logic [WIDTH-1:0] dir_q;
	logic [WIDTH-1:0] lat_q;
	logic [7:0]       memctl_q;
	logic [7:0]       latch_a_register_q;
	logic [7:0]       ppctl_q;
	logic [WIDTH-1:0] par_in_q;
	logic [WIDTH-1:0] pin_s1_q;
	logic [WIDTH-1:0] pin_s2_q;
	logic [7:0]       rdata_q;
	logic [7:0]       rdata_d;
	logic             bus_en;
	logic             par_mode;
	logic             pullup_en;
	logic [WIDTH-1:0] pwm_oe;
	logic [WIDTH-1:0] pwm_out;
	logic [WIDTH-1:0] pwm_tri;
	sdpd_bus_req_s    req;

	assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR,
		rd: REG_RD};

	// bus enabled unless disable bit set; small package has no bus
	assign bus_en = BIG & ~memctl_q[SDPD_BIT_EXT_BUS_DIS];
	assign par_mode = BIG & ~bus_en
		& ppctl_q[SDPD_BIT_PAR_SLAVE];
	assign pullup_en = latch_a_register_q[SDPD_BIT_PULLUP_EN];

	// pin synchroniser: first stage feeds only the second
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end
		else if (CLK_EN)
		begin
			pin_s1_q <= PIN_I;
			pin_s2_q <= pin_s1_q;
		end
	end

	// direction register
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
			dir_q <= SDPD_RST_DIR[WIDTH-1:0];
		else if (CLK_EN && req.wr && req.addr == SDPD_OFS_DIR)
			dir_q <= req.wdata[WIDTH-1:0];
	end

	// output latch, written through either pin or latch address
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
			lat_q <= SDPD_RST_LATCH[WIDTH-1:0];
		else if (CLK_EN && req.wr && (req.addr == SDPD_OFS_LATCH
			|| req.addr == SDPD_OFS_PIN))
			lat_q <= req.wdata[WIDTH-1:0];
	end

	// memory, pull-up and parallel control registers
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			memctl_q <= SDPD_RST_MEMCTL;
			latch_a_register_q   <= SDPD_RST_LATCH_A_REGISTER;
			ppctl_q  <= SDPD_RST_PPCTL;
		end
		else if (CLK_EN && req.wr)
		begin
			if (req.addr == SDPD_OFS_MEMCTL)
				memctl_q <= req.wdata;
			if (req.addr == SDPD_OFS_LATCH_A_REGISTER)
				latch_a_register_q <= req.wdata;
			if (req.addr == SDPD_OFS_PPCTL)
				ppctl_q <= req.wdata;
		end
	end

	// parallel host write captures pins regardless of direction
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
			par_in_q <= '0;
		else if (CLK_EN && par_mode && PAR_HOST_WR)
			par_in_q <= pin_s2_q;
	end

	// pwm/compare sources only exist on bits 0 to 2
	always_comb
	begin
		pwm_oe  = '0;
		pwm_out = '0;
		pwm_tri = '0;
		for (int i = 0; i < 3; i++)
		begin
			// only with direction zero; bit 0 pwm beats parallel data
			pwm_oe[i]  = PWM_SEL[i] & ~dir_q[i];
			pwm_out[i] = PWM_OUT[i];
			pwm_tri[i] = PWM_SHUTDOWN_TRI[i];
		end
	end

	// capture inputs see synchronised pins when selected by PWM_SEL and set as inputs
	assign CAPTURE_IN = pin_s2_q[2:0] & dir_q[2:0]
		& PWM_SEL;
	assign EXT_BUS_DIN = pin_s2_q;

	genvar g;
	generate
		for (g = 0; g < PIN_W; g++)
		begin : g_pin
			sdpd_pin_src_s src;
			assign src = '{
				bus_oe:  bus_en & EXT_BUS_ACTIVE & EXT_BUS_OE,
				bus_out: EXT_BUS_DOUT[g],
				pwm_oe:  ~bus_en & pwm_oe[g],
				pwm_tri: pwm_tri[g],
				pwm_out: pwm_out[g],
				par_oe:  par_mode & PAR_HOST_RD,
				par_out: lat_q[g],
				// with the bus enabled but idle the pins float
				dir:     bus_en | dir_q[g],
				lat:     lat_q[g]
			};
			sdpd_pin_mux u_mux (
				.src       (src),
				.pullup_en (pullup_en),
				.pin_out   (PIN_O[g]),
				.pin_oe    (PIN_OE[g]),
				.pin_pull  (PIN_PULLUP[g])
			);
		end
	endgenerate

	// read mux; latch returns latch, pin address returns pin levels
	always_comb
	begin
		rdata_d = '0;
		case (req.addr)
			SDPD_OFS_PIN:    rdata_d[WIDTH-1:0] = pin_s2_q;
			SDPD_OFS_DIR:    rdata_d[WIDTH-1:0] = dir_q;
			SDPD_OFS_LATCH:  rdata_d[WIDTH-1:0] = lat_q;
			SDPD_OFS_MEMCTL: rdata_d = memctl_q;
			SDPD_OFS_LATCH_A_REGISTER:   rdata_d = latch_a_register_q;
			SDPD_OFS_PPCTL:  rdata_d = ppctl_q;
			SDPD_OFS_PPIN:   rdata_d[WIDTH-1:0] = par_in_q;
			default:         rdata_d = '0;
		endcase
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
			rdata_q <= '0;
		else if (CLK_EN && req.rd)
			rdata_q <= rdata_d;
	end
	assign REG_RDATA = rdata_q;

	// assertions
	// direction and latch path; parallel mode excluded, it overrides
	chk_dir_input: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(CLK_EN && req.wr && req.addr == SDPD_OFS_DIR && !bus_en
		&& !par_mode && req.wdata[0] && !PWM_SEL[0]) |=> !PIN_OE[0])
		else $error("pin drives after direction set to input");
	sequence s_dir_out_wr;
		CLK_EN && req.wr && req.addr == SDPD_OFS_DIR && !bus_en
		&& !par_mode && !req.wdata[0] ##1 !PWM_SEL[0];
	endsequence
	chk_dir_output: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		s_dir_out_wr |-> (PIN_OE[0] && PIN_O[0] == lat_q[0]))
		else $error("pin not driven after direction set to output");
	chk_dir_reg: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(CLK_EN && req.wr && req.addr == SDPD_OFS_DIR)
		|=> dir_q == $past(REG_WDATA[WIDTH-1:0]))
		else $error("direction write lost");
	chk_latch_drive: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(!bus_en && !dir_q[0] && !PWM_SEL[0] && !par_mode)
		|-> (PIN_OE[0] && PIN_O[0] == lat_q[0]))
		else $error("latch not driven on output pin");
	chk_latch_read: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(CLK_EN && req.rd && req.addr == SDPD_OFS_LATCH)
		|=> REG_RDATA[WIDTH-1:0] == $past(lat_q))
		else $error("latch readback wrong");
	chk_latch_hold: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(CLK_EN && req.rd && !req.wr) |=> $stable(lat_q))
		else $error("read disturbed the latch");

	// reset checks run without disable so the reset state itself is seen
	sequence s_reset_idle;
		!RST_N ##1 !(EXT_BUS_ACTIVE && EXT_BUS_OE);
	endsequence
	chk_reset_in: assert property (@(posedge SYS_CLK)
		$rose(RST_N) |-> (dir_q == '1 && latch_a_register_q[SDPD_BIT_PULLUP_EN]))
		else $error("reset state not inputs with pull-ups");
	chk_reset_pins: assert property (@(posedge SYS_CLK)
		s_reset_idle |-> (PIN_OE == '0 && PIN_PULLUP == '1))
		else $error("pins not released with pull-ups after reset");

	// pull-ups follow the drive state, never fight our own driver
	chk_pull_out: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(PIN_OE != '0) |-> ((PIN_PULLUP & PIN_OE) == '0))
		else $error("pull-up active on driven pin");
	chk_pull_off: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		!pullup_en |-> PIN_PULLUP == '0)
		else $error("pull-up on while disabled");
	chk_pull_on: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(pullup_en && PIN_OE == '0) |-> PIN_PULLUP == '1)
		else $error("pull-up missing on released pin");

	// external bus owns pins and direction whenever it is enabled
	chk_bus_wins: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(bus_en && EXT_BUS_ACTIVE && EXT_BUS_OE)
		|-> (PIN_OE == '1 && PIN_O == EXT_BUS_DOUT))
		else $error("external bus lost the pins");
	chk_bus_owns_dir: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(bus_en && !(EXT_BUS_ACTIVE && EXT_BUS_OE)) |-> PIN_OE == '0)
		else $error("port direction leaked past enabled bus");
	chk_bus_input: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(CLK_EN && bus_en) |=> EXT_BUS_DIN == $past(pin_s1_q))
		else $error("bus input not fed from pins");

	// parallel slave: read drives latch, write captures synced pins
	chk_par_read: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(par_mode && PAR_HOST_RD && (PWM_SEL & ~dir_q[2:0]) == '0)
		|-> (PIN_OE == '1 && PIN_O == lat_q))
		else $error("parallel read not driving latch");
	sequence s_par_wr;
		CLK_EN && par_mode && PAR_HOST_WR;
	endsequence
	chk_par_cap: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		s_par_wr |=> par_in_q == $past(pin_s2_q))
		else $error("parallel write not captured");
	chk_par_data: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(CLK_EN && req.rd && req.addr == SDPD_OFS_PPIN)
		|=> REG_RDATA[WIDTH-1:0] == $past(par_in_q))
		else $error("parallel data readback wrong");

	// pwm and compare outputs beat port and parallel data when mapped
	chk_pwm0_drive: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(!bus_en && PWM_SEL[0] && !dir_q[0] && !PWM_SHUTDOWN_TRI[0])
		|-> (PIN_OE[0] && PIN_O[0] == PWM_OUT[0]))
		else $error("pwm channel lost bit 0");
	chk_cmp1_drive: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(!bus_en && PWM_SEL[1] && !dir_q[1] && !PWM_SHUTDOWN_TRI[1])
		|-> (PIN_OE[1] && PIN_O[1] == PWM_OUT[1]))
		else $error("compare output lost bit 1");
	chk_cmp2_drive: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(!bus_en && PWM_SEL[2] && !dir_q[2] && !PWM_SHUTDOWN_TRI[2])
		|-> (PIN_OE[2] && PIN_O[2] == PWM_OUT[2]))
		else $error("compare output lost bit 2");
	chk_cap1_feed: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(PWM_SEL[1] && dir_q[1]) |-> CAPTURE_IN[1] == pin_s2_q[1])
		else $error("capture input 1 not fed from pin");
	chk_cap2_feed: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(PWM_SEL[2] && dir_q[2]) |-> CAPTURE_IN[2] == pin_s2_q[2])
		else $error("capture input 2 not fed from pin");
	chk_pwm_tri: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(!bus_en && PWM_SEL[1] && !dir_q[1] && PWM_SHUTDOWN_TRI[1])
		|-> !PIN_OE[1])
		else $error("pwm shutdown did not tristate");
endmodule : sdpd_port
`default_nettype wire

// ===== tb/sdpd_pin_model.sv
// model of the board side: pin levels seen by the port
`timescale 1ns/1ps
`default_nettype none
module sdpd_pin_model
(
	// clock
	input  wire logic       clk,
	// port drive
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pull,
	// board devices
	input  wire logic [7:0] drv_en,
	input  wire logic [7:0] drv_val,
	// resolved levels
	output logic      [7:0] pin_i
);
	logic tog_q = 1'b0;

	// an undriven pin without pull-up wanders, so stale levels never match
	always_ff @(posedge clk)
		tog_q <= ~tog_q;

	// port driver wins over the board; pull-up only while nobody drives
	always_comb
		pin_i = (pin_oe & pin_o) | (~pin_oe & drv_en & drv_val)
			| (~pin_oe & ~drv_en & (pin_pull | {8{tog_q}}));
endmodule : sdpd_pin_model
`default_nettype wire

// ===== tb/shared_digital_port_d_test.sv
// self-checking bench for the shared port d
`timescale 1ns/1ps
`default_nettype none
module shared_digital_port_d_test
	import sdpd_pkg::*;
;
	typedef struct packed {
		logic [2:0] sel;
		logic [7:0] exp;
		logic [7:0] msk;
	} sdpd_note_s;

	logic       SYS_CLK, RST_N, CLK_EN, REG_WR, REG_RD, rd_seen, look;
	logic [3:0] REG_ADDR;
	logic [7:0] REG_WDATA, REG_RDATA, EXT_BUS_DOUT, EXT_BUS_DIN, PIN_I;
	logic       EXT_BUS_ACTIVE, EXT_BUS_OE, PAR_HOST_RD, PAR_HOST_WR;
	logic [2:0] PWM_SEL, PWM_OUT, PWM_SHUTDOWN_TRI, CAPTURE_IN;
	logic [7:0] PIN_O, PIN_OE, PIN_PULLUP, drv_en, drv_val, got;
	logic [7:0] d, l, v, p, t;
	int         miscompares, checked;
	sdpd_note_s notes[$];
	sdpd_note_s n;

	sdpd_port #(.WIDTH(8)) dut (
		.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.EXT_BUS_ACTIVE(EXT_BUS_ACTIVE), .EXT_BUS_OE(EXT_BUS_OE),
		.EXT_BUS_DOUT(EXT_BUS_DOUT), .EXT_BUS_DIN(EXT_BUS_DIN),
		.PAR_HOST_RD(PAR_HOST_RD), .PAR_HOST_WR(PAR_HOST_WR),
		.PWM_SEL(PWM_SEL), .PWM_OUT(PWM_OUT),
		.PWM_SHUTDOWN_TRI(PWM_SHUTDOWN_TRI), .CAPTURE_IN(CAPTURE_IN),
		.PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE),
		.PIN_PULLUP(PIN_PULLUP));

	sdpd_pin_model board (.clk(SYS_CLK), .pin_o(PIN_O), .pin_oe(PIN_OE),
		.pin_pull(PIN_PULLUP), .drv_en(drv_en), .drv_val(drv_val),
		.pin_i(PIN_I));

	initial
	begin
		SYS_CLK = 1'b0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end

	task automatic summarize();
		repeat (3) @(posedge SYS_CLK);
		if (miscompares == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	task automatic wr(input logic [3:0] a, input logic [7:0] dat);
		@(posedge SYS_CLK);
		REG_ADDR  <= a;
		REG_WDATA <= dat;
		REG_WR    <= 1'b1;
		@(posedge SYS_CLK);
		REG_WR    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		notes.push_back('{3'h0, e, 8'hff});
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_RD   <= 1'b1;
		@(posedge SYS_CLK);
		REG_RD   <= 1'b0;
	endtask : rd

	// sel: 1 pin out, 2 enable, 3 pull-up, 4 bus input, 5 capture input
	task automatic chk(input logic [2:0] s, input logic [7:0] e,
		input logic [7:0] m);
		notes.push_back('{s, e & m, m});
		@(posedge SYS_CLK);
		look <= 1'b1;
		@(posedge SYS_CLK);
		look <= 1'b0;
	endtask : chk

	function automatic logic [7:0] pick(input logic [2:0] s);
		case (s)
			3'h1: return PIN_O;
			3'h2: return PIN_OE;
			3'h3: return PIN_PULLUP;
			3'h4: return EXT_BUS_DIN;
			3'h5: return {5'h00, CAPTURE_IN};
			default: return REG_RDATA;
		endcase
	endfunction : pick

	// read data stand from the cycle after the strobe until the next read
	always @(posedge SYS_CLK)
	begin
		if (rd_seen || look)
		begin
			checked++;
			n   = notes.pop_front();
			got = pick(n.sel) & n.msk;
			if (got !== n.exp)
			begin
				miscompares++;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, n.exp);
			end
		end
		rd_seen <= REG_RD & CLK_EN;
	end

	initial
	begin
		#50000;
		miscompares++;
		summarize();
	end

	initial
	begin
		{RST_N, REG_WR, REG_RD, rd_seen, look, REG_ADDR, REG_WDATA} = '0;
		{EXT_BUS_ACTIVE, EXT_BUS_OE, EXT_BUS_DOUT, PAR_HOST_RD} = '0;
		{PAR_HOST_WR, PWM_SEL, PWM_OUT, PWM_SHUTDOWN_TRI} = '0;
		CLK_EN  = 1'b1;
		drv_en  = 8'hff;
		drv_val = 8'h00;
		void'($urandom(32'h515b47af));
		repeat (2) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		rd(SDPD_OFS_DIR, 8'hff);
		rd(SDPD_OFS_LATCH_A_REGISTER, 8'h80);
		rd(SDPD_OFS_LATCH, 8'h00);
		rd(SDPD_OFS_MEMCTL, 8'h00);
		rd(SDPD_OFS_PPCTL, 8'h00);
		rd(4'hf, 8'h00);
		chk(3'h2, 8'h00, 8'hff);
		chk(3'h3, 8'hff, 8'hff);
		// bus enabled: port direction and latch have no say
		l = 8'($urandom());
		p = 8'($urandom());
		wr(SDPD_OFS_DIR, 8'h00);
		wr(SDPD_OFS_LATCH, l);
		chk(3'h2, 8'h00, 8'hff);
		EXT_BUS_ACTIVE <= 1'b1;
		EXT_BUS_OE     <= 1'b1;
		EXT_BUS_DOUT   <= p;
		PWM_SEL        <= 3'h7;
		PWM_OUT        <= ~p[2:0];
		chk(3'h2, 8'hff, 8'hff);
		chk(3'h1, p, 8'hff);
		EXT_BUS_OE <= 1'b0;
		drv_val    <= ~p;
		repeat (3) @(posedge SYS_CLK);
		chk(3'h4, ~p, 8'hff);
		EXT_BUS_ACTIVE <= 1'b0;
		PWM_SEL        <= 3'h0;
		wr(SDPD_OFS_MEMCTL, 8'h80);
		repeat (4)
		begin
			d = 8'($urandom());
			l = 8'($urandom());
			v = 8'($urandom());
			drv_en  <= d;
			drv_val <= v;
			wr(SDPD_OFS_DIR, d);
			wr(SDPD_OFS_LATCH, l);
			chk(3'h2, ~d, 8'hff);
			chk(3'h1, l, ~d);
			chk(3'h3, d, 8'hff);
			rd(SDPD_OFS_LATCH, l);
			rd(SDPD_OFS_PIN, (d & v) | (~d & l));
		end
		wr(SDPD_OFS_PIN, v);
		rd(SDPD_OFS_LATCH, v);
		@(posedge SYS_CLK);
		CLK_EN <= 1'b0;
		wr(SDPD_OFS_DIR, ~d);
		CLK_EN <= 1'b1;
		rd(SDPD_OFS_DIR, d);
		wr(SDPD_OFS_LATCH_A_REGISTER, 8'h00);
		chk(3'h3, 8'h00, 8'hff);
		wr(SDPD_OFS_LATCH_A_REGISTER, 8'h80);
		// compare outputs on bits 0 to 2, some in shutdown
		p = 8'($urandom()) & 8'h07;
		// bit 1 always in shutdown so the tristate path is exercised
		t = (8'($urandom()) & 8'h01) | 8'h02;
		wr(SDPD_OFS_DIR, 8'hf8);
		PWM_SEL          <= 3'h7;
		PWM_OUT          <= p[2:0];
		PWM_SHUTDOWN_TRI <= t[2:0];
		chk(3'h2, ~t, 8'h07);
		chk(3'h1, p, ~t & 8'h07);
		drv_en  <= 8'hff;
		drv_val <= v;
		wr(SDPD_OFS_DIR, 8'hff);
		// released pins need two more edges through the synchroniser
		repeat (2) @(posedge SYS_CLK);
		chk(3'h5, v, 8'h07);
		// parallel slave: host read drives the latch on every pin not held by pwm
		PWM_SHUTDOWN_TRI <= 3'h0;
		wr(SDPD_OFS_PPCTL, 8'h10);
		PAR_HOST_RD <= 1'b1;
		chk(3'h2, 8'hff, 8'hff);
		chk(3'h1, v, 8'hff);
		wr(SDPD_OFS_DIR, 8'hf8);
		chk(3'h1, {v[7:3], p[2:0]}, 8'hff);
		PAR_HOST_RD <= 1'b0;
		PWM_SEL     <= 3'h0;
		drv_val     <= ~v;
		wr(SDPD_OFS_DIR, 8'hff);
		repeat (2) @(posedge SYS_CLK);
		PAR_HOST_WR <= 1'b1;
		@(posedge SYS_CLK);
		PAR_HOST_WR <= 1'b0;
		rd(SDPD_OFS_PPIN, ~v);
		// second reset in mid-run
		@(posedge SYS_CLK);
		RST_N <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		rd(SDPD_OFS_DIR, 8'hff);
		rd(SDPD_OFS_LATCH_A_REGISTER, 8'h80);
		chk(3'h2, 8'h00, 8'hff);
		summarize();
	end
endmodule : shared_digital_port_d_test
`default_nettype wire
